// ### rim_irq_pin_mux.sv
// Radio event flags, masks, request line and general-purpose pin function multiplexer
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Combined request is routed to the software-selected general-purpose pin.
// - Packet events sit at status bits 0 to 4.
// - Queue events sit at status bits 5 to 10.
// - Bit 11 sets when channel access exhausts its back-off attempts.
// - Preamble, sync and carrier events sit at bits 12 to 14.
// - Device and timer events use bits 15 to 19 and 28 to 29.
// - Wake timeout flag sets only once the crystal clock runs.
// - Ready flag sets on each ready entry after crystal readiness.
// - Status bits show occurred events and clear when the host reads them.
// - A zero mask bit stops its event from raising a request.
// - Events are reported only in their associated radio states; low battery is reported in every state.
// - Four pins, each with its own output and input function.
// - Output codes 0 to 4: request, por inverted, wake, battery, tx clock.
// - Transmit data input is sampled on each rising pclk edge; the tx clock only goes out on a pin.
// - Output codes 6 to 9: queue nearly empty, nearly full, rx data, rx clock.
// - Codes 10, 11, 12, 22, 23, 24 give radio state indications.
// - Codes 13 to 18: antenna switch, preamble, sync, carrier, tx/rx; 17 reserved.
// - Code 19 drives high, 20 low, 21 the switching regulator enable.
// - Codes 25 to 30 expose wait states, the on-off keyed tx level (26) and synthesizer enable; 31 reserved.
// - Input codes 0, 1, 2: tx command, rx command, tx data.
// - Input 3 wakes, 4 takes the slow clock, 5 to 31 do nothing.
// - Non-persistent channel access reaching its back-off limit raises the event.
module rim_irq_pin_mux (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] event_pulse,
  input  wire logic        backoff_limit_event,
  input  wire logic        backoff_persistent,
  input  wire logic        crystal_oscillator_ready,
  input  wire logic [2:0]  radio_state,
  input  wire logic        rx_entering,
  input  wire logic [12:0] pin_sources,
  input  wire logic        tx_data_clk,
  input  wire logic [3:0]  gpio_in,
  output logic      [3:0]  gpio_out,
  output logic      [3:0]  gpio_oe,
  output logic             ext_tx_cmd,
  output logic             ext_rx_cmd,
  output logic             ext_tx_data,
  output logic             ext_wake,
  output logic             ext_slow_clk,
  output logic             event_request_n
);

  // pin_sources: 0 por, 1 wake expired, 2 low batt, 3 tx cmd info, 4 q nearly empty,
  // 5 q nearly full, 6 rx data, 7 rx clk, 8 antenna switch, 9 regulator enable,
  // 10 wait lock, 11 onoff_keyed_tx_level, 12 wait osc_ready_level; waits below.
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] pincfg;
    logic [1:0]  irq_pin;
    logic        wake_pend;
    logic        xo_q;
    logic        txclk_q;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  gout;
    logic [3:0]  goe;
    logic        tx_cmd;
    logic        rx_cmd;
    logic        tx_data;
    logic        wake;
    logic        slow_clk;
    logic        req_n;
  } rim_state_s;

  rim_state_s q;
  rim_state_s d;

  rim_pkg::rim_radio_e st;
  logic [31:0] allowed;
  logic [31:0] raw;
  logic [31:0] pend;
  logic        any_pend;
  logic        bus_rd;
  logic        bus_wr;
  logic        status_rd;
  logic [3:0]  pin_val;
  logic [3:0]  sel_is_in_tx;
  logic [3:0]  sel_is_in_rx;
  logic [3:0]  sel_is_in_dat;
  logic [3:0]  sel_is_in_wk;
  logic [3:0]  sel_is_in_clk;
  localparam int SEL_W_L = rim_pkg::SEL_W;

  logic [SEL_W_L-1:0] sel [4];

  assign st = rim_pkg::rim_radio_e'(radio_state);

  // Per-event state qualification
  always_comb begin
    allowed = '0;
    allowed[rim_pkg::EV_RX_READY]   = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_RX_DISC]    = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_TX_SENT]    = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_MAX_RETX]   = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_CRC_ERR]    = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_TXQ_ERR]    = (st == rim_pkg::RIM_TX) || (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_RXQ_ERR]    = (st == rim_pkg::RIM_RX) || (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_TXQ_AFULL]  = (st == rim_pkg::RIM_TX) || (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_TXQ_AEMPTY] = (st == rim_pkg::RIM_TX);
    allowed[rim_pkg::EV_RXQ_AFULL]  = (st == rim_pkg::RIM_RX);
    allowed[rim_pkg::EV_RXQ_AEMPTY] = (st == rim_pkg::RIM_RX) || (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_BACKOFF]    = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_PREAMBLE]   = (st == rim_pkg::RIM_RX);
    allowed[rim_pkg::EV_SYNC]       = (st == rim_pkg::RIM_RX);
    allowed[rim_pkg::EV_CARRIER]    = (st == rim_pkg::RIM_RX);
    allowed[rim_pkg::EV_WAKE_TOUT]  = (st == rim_pkg::RIM_READY) || (st == rim_pkg::RIM_TX)
                                      || (st == rim_pkg::RIM_RX);
    allowed[rim_pkg::EV_READY]      = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_STBY_PEND]  = (st == rim_pkg::RIM_STANDBY);
    allowed[rim_pkg::EV_LOW_BATT]   = 1'b1;
    allowed[rim_pkg::EV_POR]        = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_RX_TOUT]    = (st == rim_pkg::RIM_READY);
    allowed[rim_pkg::EV_SNIFF_TOUT] = (st == rim_pkg::RIM_READY);
  end

  // Raw event vector; bits outside the map never set
  always_comb begin
    raw = event_pulse & rim_pkg::EVT_VALID;
    // Back-off limit only counts in non-persistent mode
    raw[rim_pkg::EV_BACKOFF] = backoff_limit_event & ~backoff_persistent;
    // Wake timeout waits for the crystal clock; held pending so it is not lost
    raw[rim_pkg::EV_WAKE_TOUT] = (q.wake_pend | event_pulse[rim_pkg::EV_WAKE_TOUT]) & q.xo_q;
    // Ready flag only on entry with crystal ready
    raw[rim_pkg::EV_READY] = event_pulse[rim_pkg::EV_READY] & q.xo_q;
  end

  assign bus_rd    = psel & penable & ~pwrite;
  assign bus_wr    = psel & penable & pwrite;
  assign status_rd = bus_rd && q.pready && (paddr == rim_pkg::OFF_STATUS);
  assign pend      = q.status & q.mask;
  assign any_pend  = |pend;

  // Pin function decode: one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < rim_pkg::PIN_CNT; gi++) begin : g_pin
      assign sel[gi] = q.pincfg[gi*rim_pkg::PIN_STRIDE +: SEL_W_L];
      always_comb begin
        pin_val[gi] = 1'b0;
        case (sel[gi])
          rim_pkg::OUT_REQ_N:     pin_val[gi] = ~any_pend;
          rim_pkg::OUT_POR_N:     pin_val[gi] = ~pin_sources[0];
          rim_pkg::OUT_WAKE_EXP:  pin_val[gi] = pin_sources[1];
          rim_pkg::OUT_LOW_BATT:  pin_val[gi] = pin_sources[2];
          rim_pkg::OUT_TX_CLK:    pin_val[gi] = q.txclk_q;
          rim_pkg::OUT_TX_CMD:    pin_val[gi] = pin_sources[3];
          rim_pkg::OUT_Q_AEMPTY:  pin_val[gi] = pin_sources[4];
          rim_pkg::OUT_Q_AFULL:   pin_val[gi] = pin_sources[5];
          rim_pkg::OUT_RX_DATA:   pin_val[gi] = pin_sources[6];
          rim_pkg::OUT_RX_CLK:    pin_val[gi] = pin_sources[7];
          rim_pkg::OUT_RX_ENTER:  pin_val[gi] = rx_entering;
          rim_pkg::OUT_AWAKE:     pin_val[gi] = (st != rim_pkg::RIM_SLEEP) && (st != rim_pkg::RIM_STANDBY);
          rim_pkg::OUT_STANDBY:   pin_val[gi] = (st == rim_pkg::RIM_STANDBY);
          rim_pkg::OUT_ANT_SW:    pin_val[gi] = pin_sources[8];
          rim_pkg::OUT_PREAMBLE:  pin_val[gi] = q.status[rim_pkg::EV_PREAMBLE];
          rim_pkg::OUT_SYNC:      pin_val[gi] = q.status[rim_pkg::EV_SYNC];
          rim_pkg::OUT_CARRIER:   pin_val[gi] = event_pulse[rim_pkg::EV_CARRIER];
          rim_pkg::OUT_TRX_MODE:  pin_val[gi] = (st == rim_pkg::RIM_TX) || (st == rim_pkg::RIM_RX);
          rim_pkg::OUT_HIGH:      pin_val[gi] = 1'b1;
          rim_pkg::OUT_LOW:       pin_val[gi] = 1'b0;
          rim_pkg::OUT_REG_EN:    pin_val[gi] = pin_sources[9];
          rim_pkg::OUT_SLEEP:     pin_val[gi] = (st == rim_pkg::RIM_SLEEP);
          rim_pkg::OUT_READY:     pin_val[gi] = (st == rim_pkg::RIM_READY);
          rim_pkg::OUT_LOCK:      pin_val[gi] = (st == rim_pkg::RIM_LOCK);
          rim_pkg::OUT_WAIT_LOCK: pin_val[gi] = pin_sources[10];
          rim_pkg::OUT_OOK_LEVEL: pin_val[gi] = pin_sources[11];
          rim_pkg::OUT_WAIT_OSC:  pin_val[gi] = pin_sources[12];
          rim_pkg::OUT_WAIT_PWR:  pin_val[gi] = ~q.xo_q;
          rim_pkg::OUT_WAIT_CAL:  pin_val[gi] = (st == rim_pkg::RIM_LOCK);
          rim_pkg::OUT_SYN_FULL:  pin_val[gi] = (st == rim_pkg::RIM_LOCK) || (st == rim_pkg::RIM_RX)
                                                || (st == rim_pkg::RIM_TX);
          default:                pin_val[gi] = 1'b0;
        endcase
      end
      // Bit 7 of each pin byte turns the pin into an input
      assign sel_is_in_tx[gi]  = q.pincfg[gi*rim_pkg::PIN_STRIDE + 7] && sel[gi] == rim_pkg::IN_TX_CMD;
      assign sel_is_in_rx[gi]  = q.pincfg[gi*rim_pkg::PIN_STRIDE + 7] && sel[gi] == rim_pkg::IN_RX_CMD;
      assign sel_is_in_dat[gi] = q.pincfg[gi*rim_pkg::PIN_STRIDE + 7] && sel[gi] == rim_pkg::IN_TX_DATA;
      assign sel_is_in_wk[gi]  = q.pincfg[gi*rim_pkg::PIN_STRIDE + 7] && sel[gi] == rim_pkg::IN_WAKE;
      assign sel_is_in_clk[gi] = q.pincfg[gi*rim_pkg::PIN_STRIDE + 7] && sel[gi] == rim_pkg::IN_SLOW_CLK;
    end
  endgenerate

  always_comb begin
    d = q;
    d.xo_q    = crystal_oscillator_ready;
    d.txclk_q = tx_data_clk;
    // Wake timeout waits here until the crystal clock is up
    d.wake_pend = (q.wake_pend | event_pulse[rim_pkg::EV_WAKE_TOUT]) & ~q.xo_q;
    // Read clears only the bits handed out at setup, so a flag set during the access survives; set wins
    d.status = (status_rd ? (q.status & ~q.prdata) : q.status) | (raw & allowed);
    d.pready  = psel & ~penable;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == rim_pkg::OFF_STATUS) begin
        d.prdata = q.status;
      end else if (paddr == rim_pkg::OFF_MASK) begin
        d.prdata = q.mask;
      end else if (paddr == rim_pkg::OFF_PINCFG) begin
        d.prdata = q.pincfg;
      end else if (paddr == rim_pkg::OFF_IRQPIN) begin
        d.prdata = {30'h0, q.irq_pin};
      end else if (paddr == rim_pkg::OFF_STATE) begin
        d.prdata = {28'h000_0000, q.xo_q, radio_state};
      end else begin
        d.prdata  = 32'h0000_0000;
        d.pslverr = ~pwrite;
      end
      if (pwrite && !(paddr == rim_pkg::OFF_MASK || paddr == rim_pkg::OFF_PINCFG
                      || paddr == rim_pkg::OFF_IRQPIN || paddr == rim_pkg::OFF_STATUS
                      || paddr == rim_pkg::OFF_STATE)) begin
        d.pslverr = 1'b1;
      end
    end
    if (bus_wr && q.pready) begin
      if (paddr == rim_pkg::OFF_MASK) begin
        d.mask = pwdata & rim_pkg::EVT_VALID;
      end else if (paddr == rim_pkg::OFF_PINCFG) begin
        d.pincfg = pwdata;
      end else if (paddr == rim_pkg::OFF_IRQPIN) begin
        d.irq_pin = pwdata[1:0];
      end
    end
    // Request follows registered pairs, so it drops the cycle after the clearing read
    d.req_n = ~any_pend;
    d.gout  = 4'h0;
    d.goe   = 4'h0;
    for (int i = 0; i < rim_pkg::PIN_CNT; i++) begin
      d.goe[i]  = ~q.pincfg[i*rim_pkg::PIN_STRIDE + 7];
      d.gout[i] = pin_val[i];
    end
    // Selected request pin overrides its own function
    d.gout[q.irq_pin] = ~any_pend;
    d.goe[q.irq_pin]  = 1'b1;
    // Inputs are level samples; unused codes have no effect
    d.tx_cmd   = |(sel_is_in_tx & gpio_in);
    d.rx_cmd   = |(sel_is_in_rx & gpio_in);
    d.tx_data  = |(sel_is_in_dat & gpio_in);
    d.wake     = |(sel_is_in_wk & gpio_in);
    d.slow_clk = |(sel_is_in_clk & gpio_in);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.mask    <= rim_pkg::MASK_RST;
      q.pincfg  <= rim_pkg::PINCFG_RST;
      q.irq_pin <= rim_pkg::IRQPIN_RST;
      q.req_n   <= 1'b1;
      q.goe     <= 4'h1;
      q.gout    <= 4'h1;
    end else begin
      q <= d;
    end
  end

  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign gpio_out        = q.gout;
  assign gpio_oe         = q.goe;
  assign ext_tx_cmd      = q.tx_cmd;
  assign ext_rx_cmd      = q.rx_cmd;
  assign ext_tx_data     = q.tx_data;
  assign ext_wake        = q.wake;
  assign ext_slow_clk    = q.slow_clk;
  assign event_request_n = q.req_n;

endmodule // rim_irq_pin_mux

`default_nettype wire

// ### rim_pkg.sv
// Package with register map, field layout and encodings of the radio event and pin-function block
package rim_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_MASK     = 8'h04;
  localparam logic [7:0] OFF_PINCFG   = 8'h08;
  localparam logic [7:0] OFF_IRQPIN   = 8'h0c;
  localparam logic [7:0] OFF_STATE    = 8'h10;

  // Reset values
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;
  localparam logic [31:0] PINCFG_RST  = 32'h0000_0000;
  localparam logic [1:0]  IRQPIN_RST  = 2'h0;

  // Valid event bits: 0..19 and 28..29
  localparam logic [31:0] EVT_VALID   = 32'h300f_ffff;

  // Event bit positions
  localparam int EV_RX_READY   = 0;
  localparam int EV_RX_DISC    = 1;
  localparam int EV_TX_SENT    = 2;
  localparam int EV_MAX_RETX   = 3;
  localparam int EV_CRC_ERR    = 4;
  localparam int EV_TXQ_ERR    = 5;
  localparam int EV_RXQ_ERR    = 6;
  localparam int EV_TXQ_AFULL  = 7;
  localparam int EV_TXQ_AEMPTY = 8;
  localparam int EV_RXQ_AFULL  = 9;
  localparam int EV_RXQ_AEMPTY = 10;
  localparam int EV_BACKOFF    = 11;
  localparam int EV_PREAMBLE   = 12;
  localparam int EV_SYNC       = 13;
  localparam int EV_CARRIER    = 14;
  localparam int EV_WAKE_TOUT  = 15;
  localparam int EV_READY      = 16;
  localparam int EV_STBY_PEND  = 17;
  localparam int EV_LOW_BATT   = 18;
  localparam int EV_POR        = 19;
  localparam int EV_RX_TOUT    = 28;
  localparam int EV_SNIFF_TOUT = 29;

  // Pin configuration field layout: pin n uses bits [8n+4:8n] code, bit 8n+7 input mode
  localparam int PIN_CNT       = 4;
  localparam int SEL_W         = 5;
  localparam int PIN_STRIDE    = 8;

  // Output selection codes
  localparam logic [4:0] OUT_REQ_N      = 5'h00;
  localparam logic [4:0] OUT_POR_N      = 5'h01;
  localparam logic [4:0] OUT_WAKE_EXP   = 5'h02;
  localparam logic [4:0] OUT_LOW_BATT   = 5'h03;
  localparam logic [4:0] OUT_TX_CLK     = 5'h04;
  localparam logic [4:0] OUT_TX_CMD     = 5'h05;
  localparam logic [4:0] OUT_Q_AEMPTY   = 5'h06;
  localparam logic [4:0] OUT_Q_AFULL    = 5'h07;
  localparam logic [4:0] OUT_RX_DATA    = 5'h08;
  localparam logic [4:0] OUT_RX_CLK     = 5'h09;
  localparam logic [4:0] OUT_RX_ENTER   = 5'h0a;
  localparam logic [4:0] OUT_AWAKE      = 5'h0b;
  localparam logic [4:0] OUT_STANDBY    = 5'h0c;
  localparam logic [4:0] OUT_ANT_SW     = 5'h0d;
  localparam logic [4:0] OUT_PREAMBLE   = 5'h0e;
  localparam logic [4:0] OUT_SYNC       = 5'h0f;
  localparam logic [4:0] OUT_CARRIER    = 5'h10;
  localparam logic [4:0] OUT_TRX_MODE   = 5'h12;
  localparam logic [4:0] OUT_HIGH       = 5'h13;
  localparam logic [4:0] OUT_LOW        = 5'h14;
  localparam logic [4:0] OUT_REG_EN     = 5'h15;
  localparam logic [4:0] OUT_SLEEP      = 5'h16;
  localparam logic [4:0] OUT_READY      = 5'h17;
  localparam logic [4:0] OUT_LOCK       = 5'h18;
  localparam logic [4:0] OUT_WAIT_LOCK  = 5'h19;
  localparam logic [4:0] OUT_OOK_LEVEL  = 5'h1a;
  localparam logic [4:0] OUT_WAIT_OSC   = 5'h1b;
  localparam logic [4:0] OUT_WAIT_PWR   = 5'h1c;
  localparam logic [4:0] OUT_WAIT_CAL   = 5'h1d;
  localparam logic [4:0] OUT_SYN_FULL   = 5'h1e;

  // Input selection codes
  localparam logic [4:0] IN_TX_CMD      = 5'h00;
  localparam logic [4:0] IN_RX_CMD      = 5'h01;
  localparam logic [4:0] IN_TX_DATA     = 5'h02;
  localparam logic [4:0] IN_WAKE        = 5'h03;
  localparam logic [4:0] IN_SLOW_CLK    = 5'h04;

  // Radio states, Gray-coded along sleep-standby-ready-lock-rx-tx path
  typedef enum logic [2:0] {
    RIM_SLEEP   = 3'h0,
    RIM_STANDBY = 3'h1,
    RIM_READY   = 3'h3,
    RIM_LOCK    = 3'h2,
    RIM_RX      = 3'h6,
    RIM_TX      = 3'h7
  } rim_radio_e;

endpackage

// ### rim_irq_pin_mux_asserts.sv
// Port-level assertions for the radio event and pin-function block
`timescale 1ns/1ps
`default_nettype none
module rim_irq_pin_mux_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] event_pulse,
  input wire logic        backoff_limit_event,
  input wire logic        backoff_persistent,
  input wire logic        crystal_oscillator_ready,
  input wire logic        event_request_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc     = psel && penable && pready;
  wire stat_rd = acc && !pwrite && paddr == rim_pkg::OFF_STATUS;
  wire mask_wr = acc && pwrite && paddr == rim_pkg::OFF_MASK;
  // Bit 11 on the event bus is ignored; only non-persistent back-off counts
  wire evt_any = |(event_pulse & rim_pkg::EVT_VALID & ~32'h0000_0800) || (backoff_limit_event && !backoff_persistent);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_PREADY_AFTER_SETUP: assert property (s_setup |=> s_access) else $error("no answer after setup");
  AST_PREADY_ONE_CYCLE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_PREADY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("pready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property ((s_setup ##0 (paddr > 8'h10)) |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_MAPPED_NO_ERR: assert property ((s_setup ##0 (paddr <= 8'h10 && paddr[1:0] == 2'h0)) |=> !pslverr)
    else $error("mapped access refused");
  AST_REQ_FALL_CAUSE: assert property ($fell(event_request_n) |->
    $past(evt_any, 2) || $past(mask_wr, 2) || !$past(crystal_oscillator_ready, 4))
    else $error("request raised without event or mask change");
  AST_REQ_RISE_CAUSE: assert property ($rose(event_request_n) |->
    $past(stat_rd, 2) || $past(mask_wr, 2)) else $error("request released without status read or mask write");
endmodule // rim_irq_pin_mux_chk

bind rim_irq_pin_mux rim_irq_pin_mux_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pulse(event_pulse),
  .backoff_limit_event(backoff_limit_event), .backoff_persistent(backoff_persistent),
  .crystal_oscillator_ready(crystal_oscillator_ready), .event_request_n(event_request_n)
);
`default_nettype wire

// ### rim_host_model.sv
// Host-side model: resolves the four pins and drives those the host owns
`timescale 1ns/1ps
`default_nettype none
module rim_host_model (
  input  wire logic       pclk,
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  input  wire logic [3:0] host_level,
  input  wire logic [3:0] host_oe,
  output logic      [3:0] pin_level
);
  logic [3:0] float_q = 4'h5;
  // Pins have no pull, so an undriven pin shows a changing pattern, never a stale level
  always @(posedge pclk) float_q <= ~float_q;
  // Host holds its command or data level steady while the device samples it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = gpio_oe[i] ? gpio_out[i] : host_oe[i] ? host_level[i] : float_q[i];
    end
  end
endmodule // rim_host_model
`default_nettype wire

// ### radio_irq_and_pin_mux_tb.sv
// Self-checking testbench for the radio event and pin-function block
`timescale 1ns/1ps
`default_nettype none
module radio_irq_and_pin_mux_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, event_pulse, rd;
  logic        bo_evt, bo_pers, xo_rdy, rx_ent, tx_clk;
  logic        ext_tx, ext_rx, ext_txd, ext_wk, ext_slk, req_n;
  logic [2:0]  st;
  logic [3:0]  gpio_in, gpio_out, gpio_oe, host_lvl, host_oe;
  logic [12:0] src;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #4 pclk = ~pclk;

  rim_irq_pin_mux u_rim_irq_pin_mux (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pulse(event_pulse), .backoff_limit_event(bo_evt), .backoff_persistent(bo_pers),
    .crystal_oscillator_ready(xo_rdy), .radio_state(st), .rx_entering(rx_ent), .pin_sources(src),
    .tx_data_clk(tx_clk), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_tx_cmd(ext_tx),
    .ext_rx_cmd(ext_rx), .ext_tx_data(ext_txd), .ext_wake(ext_wk), .ext_slow_clk(ext_slk), .event_request_n(req_n));
  rim_host_model u_rim_host_model (.pclk(pclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .host_level(host_lvl),
    .host_oe(host_oe), .pin_level(gpio_in));

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      cmp("pready wait", 32'h1, 32'h0);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask

  // Bit 11 can only come from the back-off line, so it is routed there
  task automatic evt(input int b, input logic [2:0] s);
    @(posedge pclk);
    st <= s;
    @(posedge pclk);
    if (b == 11) bo_evt <= 1'b1;
    else event_pulse <= 32'h1 << b;
    @(posedge pclk);
    bo_evt <= 1'b0;
    event_pulse <= 32'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset;
    cmp("request idle", 32'h1, req_n);
    cmp("pin drive", 32'h1, gpio_oe);
    cmp("pin0 level", 32'h1, gpio_out[0]);
    rdc(rim_pkg::OFF_MASK, rim_pkg::MASK_RST, "mask");
    rdc(rim_pkg::OFF_PINCFG, rim_pkg::PINCFG_RST, "pincfg");
    rdc(rim_pkg::OFF_IRQPIN, 32'(rim_pkg::IRQPIN_RST), "irqpin");
    apb(1'b0, 8'h20, 32'h0);
    cmp("unmapped error", 32'h1, err);
    apb(1'b1, rim_pkg::OFF_PINCFG, 32'h1f1f_1f1f);
    rdc(rim_pkg::OFF_PINCFG, 32'h1f1f_1f1f, "pincfg codes");
    apb(1'b1, rim_pkg::OFF_PINCFG, 32'h0);
  endtask

  task automatic t_events;
    int         b [22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 28, 29};
    logic [2:0] s [22] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h6, 3'h7, 3'h7, 3'h6, 3'h3, 3'h3, 3'h6, 3'h6,
                           3'h6, 3'h3, 3'h3, 3'h1, 3'h0, 3'h3, 3'h3, 3'h3};
    for (int i = 0; i < 22; i++) begin
      evt(b[i], s[i]);
      rdc(rim_pkg::OFF_STATUS, 32'h1 << b[i], "status bit");
      rdc(rim_pkg::OFF_STATUS, 32'h0, "status after read");
    end
    evt(8, 3'h6);
    evt(17, 3'h3);
    evt(12, 3'h7);
    bo_pers <= 1'b1;
    evt(11, 3'h3);
    bo_pers <= 1'b0;
    event_pulse <= 32'h800;
    @(posedge pclk);
    event_pulse <= 32'h0;
    rdc(rim_pkg::OFF_STATUS, 32'h0, "dropped events");
  endtask

  task automatic t_xo;
    apb(1'b1, rim_pkg::OFF_MASK, 32'h0001_8000);
    xo_rdy <= 1'b0;
    evt(15, 3'h3);
    evt(16, 3'h3);
    cmp("request before crystal", 32'h1, req_n);
    xo_rdy <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp("request after crystal", 32'h0, req_n);
    rdc(rim_pkg::OFF_STATUS, 32'h8000, "held wake flag");
    apb(1'b1, rim_pkg::OFF_MASK, 32'h0);
  endtask

  task automatic t_mask;
    apb(1'b1, rim_pkg::OFF_MASK, 32'h1);
    evt(1, 3'h3);
    cmp("masked event", 32'h1, req_n);
    evt(0, 3'h3);
    cmp("request", 32'h0, req_n);
    cmp("request pin", 32'h0, gpio_out[0]);
    rdc(rim_pkg::OFF_STATUS, 32'h3, "both flags");
    repeat (4) @(posedge pclk);
    cmp("request released", 32'h1, req_n);
    cmp("request pin released", 32'h1, gpio_out[0]);
    apb(1'b1, rim_pkg::OFF_MASK, 32'h0);
  endtask

  task automatic t_pins;
    logic [4:0] c [5] = '{rim_pkg::OUT_AWAKE, rim_pkg::OUT_STANDBY, rim_pkg::OUT_SLEEP, rim_pkg::OUT_READY,
                          rim_pkg::OUT_LOCK};
    logic [2:0] r [5] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h2};
    logic [2:0] sv [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};
    apb(1'b1, rim_pkg::OFF_IRQPIN, 32'h3);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, rim_pkg::OFF_PINCFG, {11'h0, c[i], 3'h0, rim_pkg::OUT_LOW, 3'h0, rim_pkg::OUT_HIGH});
      for (int j = 0; j < 5; j++) begin
        st <= sv[j];
        repeat (3) @(posedge pclk);
        cmp("state pin", (i == 0) ? (sv[j] > 3'h1) : (sv[j] == r[i]), gpio_out[2]);
      end
    end
    cmp("fixed pins", 32'h1, gpio_out[1:0]);
    cmp("pins driven", 32'h7, gpio_oe[2:0]);
    apb(1'b1, rim_pkg::OFF_PINCFG, {19'h0, rim_pkg::OUT_TX_CLK, 3'h0, rim_pkg::OUT_RX_ENTER});
    for (int v = 0; v < 2; v++) begin
      tx_clk <= v[0];
      rx_ent <= v[0];
      repeat (3) @(posedge pclk);
      cmp("clock and rx pins", {30'h0, v[0], v[0]}, gpio_out[1:0]);
    end
    apb(1'b1, rim_pkg::OFF_PINCFG, {11'h0, rim_pkg::OUT_WAIT_LOCK, 3'h0, rim_pkg::OUT_REG_EN, 3'h0, rim_pkg::OUT_POR_N});
    for (int v = 0; v < 2; v++) begin
      src <= v[0] ? 13'h0601 : 13'h0000;
      repeat (3) @(posedge pclk);
      cmp("source pins", {29'h0, v[0], v[0], ~v[0]}, gpio_out[2:0]);
    end
    apb(1'b1, rim_pkg::OFF_MASK, 32'h4);
    evt(2, 3'h3);
    cmp("request on pin3", 32'h0, gpio_out[3]);
    rdc(rim_pkg::OFF_STATUS, 32'h4, "sent flag");
    apb(1'b1, rim_pkg::OFF_MASK, 32'h0);
  endtask

  task automatic t_inputs;
    host_oe <= 4'h1;
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, rim_pkg::OFF_PINCFG, 32'h80 | c);
      host_lvl <= 4'h1;
      repeat (3) @(posedge pclk);
      cmp("input function", (c < 5) ? 32'h10 >> c : 32'h0, {ext_tx, ext_rx, ext_txd, ext_wk, ext_slk});
      cmp("input pin released", 32'h0, gpio_oe[0]);
      host_lvl <= 4'h0;
      repeat (3) @(posedge pclk);
      cmp("input low", 32'h0, {ext_tx, ext_rx, ext_txd, ext_wk, ext_slk});
    end
    host_oe <= 4'h0;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, bo_evt, bo_pers, rx_ent, tx_clk} = 7'h00;
    {paddr, pwdata, event_pulse} = 72'h0;
    xo_rdy = 1'b1;
    st = 3'h3;
    host_lvl = 4'h0;
    host_oe = 4'h0;
    src = 13'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_xo();
    t_mask();
    t_pins();
    t_inputs();
    end_of_test();
  end
endmodule // radio_irq_and_pin_mux_tb
`default_nettype wire
